/* sim/buck_voltage_select_regs_bench.sv */
`include "rail_volt_defs.svh"

module buck_voltage_select_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;

`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

  logic i_mclk, i_reset, i_sleep_n, i_rail4_passive, host_scl, host_oe, o_sda_out, o_sda_oe;
  logic [1:0] i_variant;
  logic [2:0] i_range_25mv;
  logic [6:0] i_rail4_normal_code;
  logic [2:0][6:0] o_ref_code;
  logic [2:0] o_active_pull;
  logic [2:0][11:0] o_target_mv;
  wire sda = !(host_oe || (o_sda_oe && !o_sda_out));
  int error_cnt = 0;
  int tests_run = 0;
  int seed = 32'h988a;
  logic [7:0] exp_reg [4];
  logic [7:0] rd;
  logic [15:0] rd16;
  logic ok;
  // Factory values per register (0x95..0x98) and variant 0..3
  logic [7:0] rst_tab [4][4] = '{'{8'h28, 8'h00, 8'he8, 8'ha8}, '{8'h70, 8'he8, 8'h40, 8'he8},
                                 '{8'h70, 8'he8, 8'h40, 8'he8}, '{8'hbe, 8'hdc, 8'h70, 8'h58}};

  buck_voltage_select_regs uut (.i_mclk(i_mclk), .i_reset(i_reset), .i_scl(host_scl),
    .i_sda_in(sda), .i_sleep_n(i_sleep_n), .i_variant(i_variant),
    .i_range_25mv(i_range_25mv), .i_rail4_normal_code(i_rail4_normal_code),
    .i_rail4_passive(i_rail4_passive), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
    .o_ref_code(o_ref_code), .o_active_pull(o_active_pull), .o_target_mv(o_target_mv));

  i2c_host_model host (.i_mclk(i_mclk), .i_sda(sda), .o_scl(host_scl), .o_sda_oe(host_oe));

  always #20 i_mclk = ~i_mclk;

  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic do_reset(input int v);
    @(posedge i_mclk);
    i_variant <= 2'(v);
    i_reset <= 1'b1;
    repeat (20) @(posedge i_mclk);
    i_reset <= 1'b0;
    for (int r = 0; r < 4; r++) begin
      exp_reg[r] = rst_tab[r][v];
    end
    @(posedge i_mclk);
  endtask

  task automatic check_regs;
    for (int r = 0; r < 4; r++) begin
      host.read_reg(8'h95 + 8'(r), rd);
      `CHK("register", exp_reg[r], rd)
    end
  endtask

  // Long enough for a full-scale ramp at one step per 26 clocks
  task automatic settle_and_check;
    logic [6:0] ec [3];
    logic [11:0] em;
    repeat (3400) @(posedge i_mclk);
    ec[0] = i_sleep_n ? i_rail4_normal_code : exp_reg[0][7:1];
    ec[1] = i_sleep_n ? exp_reg[1][7:1] : exp_reg[2][7:1];
    ec[2] = exp_reg[3][7:1];
    for (int k = 0; k < 3; k++) begin
      em = 12'(400 + int'(ec[k]) * (i_range_25mv[k] ? 25 : 10));
      `CHK("ref code", ec[k], o_ref_code[k])
      `CHK("millivolts", em, o_target_mv[k])
      `CHK("pull idle", 1'b0, o_active_pull[k])
    end
  endtask

  task automatic write_chk(input logic [7:0] ptr, input logic [7:0] d);
    host.write_reg(`I2C_DEV_ADDR, ptr, d, ok);
    `CHK("ack", 1'b1, ok)
    if (ptr >= 8'h95 && ptr <= 8'h98) begin
      exp_reg[ptr - 8'h95] = (ptr[0]) ? {d[7:1], exp_reg[ptr - 8'h95][0]} : d;
    end
  endtask

  initial begin
    repeat (100000) @(posedge i_mclk);
    error_cnt++;
    results();
  end

  initial begin
    i_mclk = 1'b0;
    i_reset = 1'b1;
    i_sleep_n = 1'b1;
    i_variant = 2'h0;
    i_range_25mv = 3'h0;
    i_rail4_normal_code = 7'h00;
    i_rail4_passive = 1'b0;
    for (int v = 0; v < 4; v++) begin
      do_reset(v);
      check_regs();
      `CHK("sda driver", 1'b0, o_sda_out)
    end
    // Bit 0 always set, so a reserved bit that took the write would show on read
    for (int r = 0; r < 4; r++) begin
      write_chk(8'h95 + 8'(r), 8'($random(seed)) | 8'h01);
    end
    check_regs();
    host.read_two(8'h96, rd16);
    `CHK("burst read", {exp_reg[1], exp_reg[2]}, rd16)
    // Unmapped place is acknowledged and dropped, a foreign address is refused
    write_chk(8'h99, 8'h5a);
    host.read_reg(8'h99, rd);
    `CHK("unmapped", 8'h00, rd)
    host.write_reg(`I2C_DEV_ADDR ^ 7'h01, 8'h98, 8'h11, ok);
    `CHK("foreign ack", 1'b0, ok)
    check_regs();
    for (int s = 0; s < 2; s++) begin
      @(posedge i_mclk);
      i_sleep_n <= s[0];
      i_range_25mv <= 3'($random(seed));
      i_rail4_normal_code <= 7'($random(seed));
      i_rail4_passive <= 1'($random(seed));
      settle_and_check();
    end
    for (int p = 0; p < 2; p++) begin
      write_chk(8'h98, 8'he0);
      settle_and_check();
      write_chk(8'h98, {7'h20, p[0]});
      // Look between edges, where the registered outputs have settled
      @(negedge i_mclk);
      if (p == 0) begin
        `CHK("active pull", 1'b1, o_active_pull[2])
        `CHK("slewing", 1'b1, o_ref_code[2] > 7'h20)
      end else begin
        `CHK("no pull", 1'b0, o_active_pull[2])
        `CHK("decayed", 7'h20, o_ref_code[2])
      end
      settle_and_check();
    end
    results();
  end
endmodule

/* sim/i2c_host_model.sv */
`include "rail_volt_defs.svh"

module i2c_host_model (
  input wire logic i_mclk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // Setup and hold phase, 6 of the 20 clocks of a bit; the low phase is two of these, so the device has left
  // its acknowledge before the next rising clock
  localparam int Q = 6;

  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  task automatic bit_out(input logic b);
    o_sda_oe <= ~b;
    tick(Q);
    o_scl <= 1'b1;
    tick(8);
    o_scl <= 1'b0;
    tick(Q);
  endtask

  task automatic bit_in(output logic b);
    o_sda_oe <= 1'b0;
    tick(Q);
    o_scl <= 1'b1;
    tick(8);
    b = i_sda;
    o_scl <= 1'b0;
    tick(Q);
  endtask

  // Serves as a first and as a repeated start
  task automatic start;
    o_sda_oe <= 1'b0;
    tick(Q);
    o_scl <= 1'b1;
    tick(Q);
    o_sda_oe <= 1'b1;
    tick(Q);
    o_scl <= 1'b0;
    tick(Q);
  endtask

  task automatic stop;
    o_sda_oe <= 1'b1;
    tick(Q);
    o_scl <= 1'b1;
    tick(Q);
    o_sda_oe <= 1'b0;
    tick(Q);
  endtask

  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_out(d[i]);
    end
    bit_in(b);
    ack = ~b;
  endtask

  task automatic write_reg(input logic [6:0] a, input logic [7:0] ptr, input logic [7:0] d,
                           output logic ok);
    logic a0;
    logic a1;
    logic a2;
    start();
    byte_out({a, 1'b0}, a0);
    byte_out(ptr, a1);
    byte_out(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask

  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
    logic ack;
    start();
    byte_out({`I2C_DEV_ADDR, 1'b0}, ack);
    byte_out(ptr, ack);
    start();
    byte_out({`I2C_DEV_ADDR, 1'b1}, ack);
    for (int i = 7; i >= 0; i--) begin
      bit_in(d[i]);
    end
    // Host does not acknowledge the last byte
    bit_out(1'b1);
    stop();
  endtask

  // Two bytes in one transfer: the host acknowledges the first, so the pointer steps
  task automatic read_two(input logic [7:0] ptr, output logic [15:0] d);
    logic ack;
    start();
    byte_out({`I2C_DEV_ADDR, 1'b0}, ack);
    byte_out(ptr, ack);
    start();
    byte_out({`I2C_DEV_ADDR, 1'b1}, ack);
    for (int i = 15; i >= 0; i--) begin
      bit_in(d[i]);
      if (i == 8) begin
        bit_out(1'b0);
      end
    end
    bit_out(1'b1);
    stop();
  endtask
endmodule

/* src/buck_voltage_select_regs.sv */
`include "rail_volt_defs.svh"

module buck_voltage_select_regs (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda_in,
  input wire logic i_sleep_n,
  input wire logic [1:0] i_variant,
  input wire logic [2:0] i_range_25mv,
  input wire logic [6:0] i_rail4_normal_code,
  input wire logic i_rail4_passive,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic [2:0][6:0] o_ref_code,
  output logic [2:0] o_active_pull,
  output logic [2:0][11:0] o_target_mv
);

  // Pin synchronisers: meta stage feeds only the sync stage
  rail_volt_pkg::pin_t pin_meta_ff;
  rail_volt_pkg::pin_t pin_sync_ff;
  rail_volt_pkg::pin_t pin_prev_ff;
  logic [1:0] variant_meta_ff;
  logic [1:0] variant_sync_ff;

  always_ff @(posedge i_mclk) begin
    pin_meta_ff <= '{scl: i_scl, sda: i_sda_in, sleep_n: i_sleep_n, range_25mv: i_range_25mv};
    pin_sync_ff <= pin_meta_ff;
    pin_prev_ff <= pin_sync_ff;
    variant_meta_ff <= i_variant;
    variant_sync_ff <= variant_meta_ff;
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // Bus conditions are judged on the settled stage and its one-cycle delay
  assign scl_rise = pin_sync_ff.scl & ~pin_prev_ff.scl;
  assign scl_fall = ~pin_sync_ff.scl & pin_prev_ff.scl;
  assign start_det = pin_sync_ff.scl & pin_prev_ff.scl & pin_prev_ff.sda & ~pin_sync_ff.sda;
  assign stop_det = pin_sync_ff.scl & pin_prev_ff.scl & ~pin_prev_ff.sda & pin_sync_ff.sda;

  // Register storage
  logic [7:0] regs_ff [0:`REG_COUNT-1];
  logic [7:0] nxt_regs [0:`REG_COUNT-1];

  function automatic logic reg_hit(input logic [7:0] ofs);
    return ofs >= `OFS_RAIL4_SLEEP && ofs <= `OFS_RAIL6_NORMAL;
  endfunction

  function automatic logic [1:0] reg_index(input logic [7:0] ofs);
    logic [7:0] d;
    d = ofs - `OFS_RAIL4_SLEEP;
    return d[1:0];
  endfunction

  function automatic logic is_sleep_reg(input logic [1:0] idx);
    return idx == `IDX_RAIL4_SLEEP || idx == `IDX_RAIL5_SLEEP;
  endfunction

  function automatic logic [7:0] reg_read(input logic [7:0] ofs, input logic [7:0] val);
    return reg_hit(ofs) ? val : 8'h00;
  endfunction

  function automatic logic [7:0] factory_value(input logic [1:0] idx, input logic [1:0] var_sel);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      `IDX_RAIL4_SLEEP: begin
        case (var_sel)
          2'h0: v = `RST_R4S_V0;
          2'h1: v = `RST_R4S_V1;
          2'h2: v = `RST_R4S_V2;
          default: v = `RST_R4S_V3;
        endcase
      end
      `IDX_RAIL5_NORMAL: begin
        case (var_sel)
          2'h0: v = `RST_R5N_V0;
          2'h1: v = `RST_R5N_V1;
          2'h2: v = `RST_R5N_V2;
          default: v = `RST_R5N_V3;
        endcase
      end
      `IDX_RAIL5_SLEEP: begin
        case (var_sel)
          2'h0: v = `RST_R5S_V0;
          2'h1: v = `RST_R5S_V1;
          2'h2: v = `RST_R5S_V2;
          default: v = `RST_R5S_V3;
        endcase
      end
      default: begin
        case (var_sel)
          2'h0: v = `RST_R6N_V0;
          2'h1: v = `RST_R6N_V1;
          2'h2: v = `RST_R6N_V2;
          default: v = `RST_R6N_V3;
        endcase
      end
    endcase
    return v;
  endfunction

  // Serial slave state
  rail_volt_pkg::i2c_state_t state_ff;
  rail_volt_pkg::i2c_state_t nxt_state;
  logic [3:0] bit_cnt_ff;
  logic [3:0] nxt_bit_cnt;
  logic [7:0] shift_ff;
  logic [7:0] nxt_shift;
  logic [7:0] ptr_ff;
  logic [7:0] nxt_ptr;
  logic rw_ff;
  logic nxt_rw;
  logic sda_oe_ff;
  logic nxt_sda_oe;
  logic wr_stb;
  logic [7:0] rd_byte;

  assign rd_byte = reg_read(ptr_ff, regs_ff[reg_index(ptr_ff)]);

  always_comb begin
    nxt_state = state_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shift = shift_ff;
    nxt_ptr = ptr_ff;
    nxt_rw = rw_ff;
    nxt_sda_oe = sda_oe_ff;
    wr_stb = 1'b0;
    if (start_det) begin
      // Repeated start is accepted from any state
      nxt_state = rail_volt_pkg::ST_ADDR;
      nxt_bit_cnt = `I2C_BIT_ZERO;
      nxt_sda_oe = 1'b0;
    end else if (stop_det) begin
      nxt_state = rail_volt_pkg::ST_IDLE;
      nxt_sda_oe = 1'b0;
    end else begin
      case (state_ff)
        rail_volt_pkg::ST_IDLE: begin
          nxt_sda_oe = 1'b0;
        end
        rail_volt_pkg::ST_ADDR, rail_volt_pkg::ST_PTR, rail_volt_pkg::ST_WDATA: begin
          if (scl_rise) begin
            nxt_shift = {shift_ff[6:0], pin_sync_ff.sda};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == `I2C_BYTE_BITS) begin
            nxt_sda_oe = 1'b1;
            if (state_ff == rail_volt_pkg::ST_ADDR) begin
              if (shift_ff[7:1] == `I2C_DEV_ADDR) begin
                nxt_rw = shift_ff[0];
                nxt_state = rail_volt_pkg::ST_ADDR_ACK;
              end else begin
                // Not our address: stay off the bus until the next start
                nxt_sda_oe = 1'b0;
                nxt_state = rail_volt_pkg::ST_IDLE;
              end
            end else if (state_ff == rail_volt_pkg::ST_PTR) begin
              nxt_ptr = shift_ff;
              nxt_state = rail_volt_pkg::ST_PTR_ACK;
            end else begin
              wr_stb = 1'b1;
              nxt_state = rail_volt_pkg::ST_WDATA_ACK;
            end
          end
        end
        rail_volt_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            nxt_bit_cnt = `I2C_BIT_ZERO;
            if (rw_ff) begin
              nxt_shift = rd_byte;
              nxt_sda_oe = ~rd_byte[7];
              nxt_state = rail_volt_pkg::ST_RDATA;
            end else begin
              nxt_sda_oe = 1'b0;
              nxt_state = rail_volt_pkg::ST_PTR;
            end
          end
        end
        rail_volt_pkg::ST_PTR_ACK, rail_volt_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            nxt_sda_oe = 1'b0;
            nxt_bit_cnt = `I2C_BIT_ZERO;
            nxt_state = rail_volt_pkg::ST_WDATA;
            if (state_ff == rail_volt_pkg::ST_WDATA_ACK) begin
              nxt_ptr = ptr_ff + 8'h01;
            end
          end
        end
        rail_volt_pkg::ST_RDATA: begin
          if (scl_rise) begin
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_ff == `I2C_BYTE_BITS) begin
              nxt_sda_oe = 1'b0;
              nxt_state = rail_volt_pkg::ST_RDATA_ACK;
            end else begin
              nxt_shift = {shift_ff[6:0], 1'b0};
              nxt_sda_oe = ~shift_ff[6];
            end
          end
        end
        rail_volt_pkg::ST_RDATA_ACK: begin
          if (scl_rise) begin
            if (pin_sync_ff.sda) begin
              // Host refused more data
              nxt_state = rail_volt_pkg::ST_IDLE;
            end else begin
              nxt_ptr = ptr_ff + 8'h01;
              nxt_state = rail_volt_pkg::ST_RD_LOAD;
            end
          end
        end
        rail_volt_pkg::ST_RD_LOAD: begin
          if (scl_fall) begin
            nxt_bit_cnt = `I2C_BIT_ZERO;
            nxt_shift = rd_byte;
            nxt_sda_oe = ~rd_byte[7];
            nxt_state = rail_volt_pkg::ST_RDATA;
          end
        end
        default: begin
          nxt_state = rail_volt_pkg::ST_IDLE;
          nxt_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state_ff <= rail_volt_pkg::ST_IDLE;
      bit_cnt_ff <= `I2C_BIT_ZERO;
      shift_ff <= 8'h00;
      ptr_ff <= 8'h00;
      rw_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bit_cnt_ff <= nxt_bit_cnt;
      shift_ff <= nxt_shift;
      ptr_ff <= nxt_ptr;
      rw_ff <= nxt_rw;
      sda_oe_ff <= nxt_sda_oe;
    end
  end

  // Open drain: only ever pull low
  assign o_sda_out = 1'b0;
  assign o_sda_oe = sda_oe_ff;

  always_comb begin
    for (int i = 0; i < `REG_COUNT; i++) begin
      nxt_regs[i] = regs_ff[i];
    end
    if (wr_stb && reg_hit(ptr_ff)) begin
      if (is_sleep_reg(reg_index(ptr_ff))) begin
        nxt_regs[reg_index(ptr_ff)] = {shift_ff[`CODE_MSB:`CODE_LSB],
                                       regs_ff[reg_index(ptr_ff)][`RAMP_BIT]};
      end else begin
        nxt_regs[reg_index(ptr_ff)] = shift_ff;
      end
    end
  end

  // variant reset values
  // Strap is sampled through its synchroniser, so reset must last three edges
  always_ff @(posedge i_mclk) begin
    for (int i = 0; i < `REG_COUNT; i++) begin
      if (i_reset) begin
        regs_ff[i] <= factory_value(2'(i), variant_sync_ff);
      end else begin
        regs_ff[i] <= nxt_regs[i];
      end
    end
  end

  // Regulation targets
  logic in_sleep;
  logic [2:0][6:0] tgt_code;
  logic [2:0] tgt_passive;

  assign in_sleep = ~pin_sync_ff.sleep_n;

  always_comb begin
    tgt_code[0] = in_sleep ? regs_ff[`IDX_RAIL4_SLEEP][`CODE_MSB:`CODE_LSB] : i_rail4_normal_code;
    tgt_passive[0] = i_rail4_passive;
    tgt_code[1] = in_sleep ? regs_ff[`IDX_RAIL5_SLEEP][`CODE_MSB:`CODE_LSB]
                           : regs_ff[`IDX_RAIL5_NORMAL][`CODE_MSB:`CODE_LSB];
    tgt_passive[1] = regs_ff[`IDX_RAIL5_NORMAL][`RAMP_BIT];
    tgt_code[2] = regs_ff[`IDX_RAIL6_NORMAL][`CODE_MSB:`CODE_LSB];
    tgt_passive[2] = regs_ff[`IDX_RAIL6_NORMAL][`RAMP_BIT];
  end

  for (genvar g = 0; g < 3; g++) begin : g_rail
    rail_ramp u_ramp (
      .i_mclk(i_mclk),
      .i_reset(i_reset),
      .i_target_code(tgt_code[g]),
      .i_passive(tgt_passive[g]),
      .i_range_25mv(pin_sync_ff.range_25mv[g]),
      .o_ref_code(o_ref_code[g]),
      .o_active_pull(o_active_pull[g]),
      .o_target_mv(o_target_mv[g])
    );
  end

  chk_rail4_sleep_target: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    in_sleep |-> tgt_code[0] == regs_ff[`IDX_RAIL4_SLEEP][`CODE_MSB:`CODE_LSB])
    else $error("rail4 sleep target not from its register");

  chk_rail5_sleep_target: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    ~pin_sync_ff.sleep_n |-> tgt_code[1] == regs_ff[`IDX_RAIL5_SLEEP][`CODE_MSB:`CODE_LSB])
    else $error("rail5 sleep target not from its register");

  chk_rail5_normal_target: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    pin_sync_ff.sleep_n |-> tgt_code[1] == regs_ff[`IDX_RAIL5_NORMAL][`CODE_MSB:`CODE_LSB])
    else $error("rail5 normal target not from its register");

  chk_rail6_normal_target: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    $changed(regs_ff[`IDX_RAIL6_NORMAL])
      |-> tgt_code[2] == regs_ff[`IDX_RAIL6_NORMAL][`CODE_MSB:`CODE_LSB]
      && tgt_passive[2] == regs_ff[`IDX_RAIL6_NORMAL][`RAMP_BIT])
    else $error("rail6 target not following its register");

  chk_rail6_write_data: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    (wr_stb && ptr_ff == `OFS_RAIL6_NORMAL) |=> regs_ff[`IDX_RAIL6_NORMAL] == $past(shift_ff))
    else $error("rail6 normal register write lost");

  chk_reserved_bit_hold: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    (wr_stb && (ptr_ff == `OFS_RAIL4_SLEEP || ptr_ff == `OFS_RAIL5_SLEEP))
      |=> regs_ff[reg_index($past(ptr_ff))][`RAMP_BIT]
        == $past(regs_ff[reg_index(ptr_ff)][`RAMP_BIT]))
    else $error("reserved sleep bit was written");

  chk_variant_reset_load: assert property (
    @(posedge i_mclk)
    i_reset ##1 !i_reset |-> regs_ff[`IDX_RAIL5_NORMAL] == factory_value(`IDX_RAIL5_NORMAL,
      $past(variant_sync_ff)) && regs_ff[`IDX_RAIL4_SLEEP] == factory_value(`IDX_RAIL4_SLEEP,
      $past(variant_sync_ff)))
    else $error("reset value does not match variant");

endmodule

/* src/rail_ramp.sv */
`include "rail_volt_defs.svh"

module rail_ramp (
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [6:0] i_target_code,
  input wire logic i_passive,
  input wire logic i_range_25mv,
  output logic [6:0] o_ref_code,
  output logic o_active_pull,
  output logic [11:0] o_target_mv
);

  localparam logic [7:0] STEP_CYC = 8'(`SLEW_STEP_CYC);

  logic [6:0] ref_ff;
  logic [6:0] nxt_ref;
  logic [7:0] tmr_ff;
  logic [7:0] nxt_tmr;
  logic pull_ff;
  logic nxt_pull;
  logic [11:0] mv_ff;
  logic [11:0] nxt_mv;

  function automatic logic [11:0] code_to_mv(input logic [6:0] code, input logic r25);
    logic [11:0] c;
    c = {5'h00, code};
    if (r25) begin
      return `BASE_25MV_MV + c * `STEP_25MV_MV;
    end
    return `BASE_10MV_MV + c * `STEP_10MV_MV;
  endfunction

  always_comb begin
    nxt_ref = ref_ff;
    nxt_pull = 1'b0;
    nxt_tmr = (tmr_ff == 8'h00) ? 8'h00 : tmr_ff - 8'h01;
    if (ref_ff < i_target_code) begin
      if (tmr_ff == 8'h00) begin
        nxt_ref = ref_ff + 7'h01;
        nxt_tmr = STEP_CYC;
      end
    end else if (ref_ff > i_target_code) begin
      if (i_passive) begin
        // Converter stops sinking; reference jumps and the load discharges the output
        nxt_ref = i_target_code;
      end else begin
        nxt_pull = 1'b1;
        if (tmr_ff == 8'h00) begin
          nxt_ref = ref_ff - 7'h01;
          nxt_tmr = STEP_CYC;
        end
      end
    end
    nxt_mv = code_to_mv(ref_ff, i_range_25mv);
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      // Soft start: reference climbs from zero after reset
      ref_ff <= 7'h00;
      tmr_ff <= 8'h00;
      pull_ff <= 1'b0;
      mv_ff <= 12'h000;
    end else begin
      ref_ff <= nxt_ref;
      tmr_ff <= nxt_tmr;
      pull_ff <= nxt_pull;
      mv_ff <= nxt_mv;
    end
  end

  assign o_ref_code = ref_ff;
  assign o_active_pull = pull_ff;
  assign o_target_mv = mv_ff;

  chk_active_slew_pull: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    (ref_ff > i_target_code && !i_passive) |=> o_active_pull && ref_ff >= $past(ref_ff) - 7'h01)
    else $error("active slew down not driven");

  chk_passive_decay_jump: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    (ref_ff > i_target_code && i_passive) |=> ref_ff == $past(i_target_code) && !o_active_pull)
    else $error("passive decay did not release the output");

  chk_step_range_mv: assert property (
    @(posedge i_mclk) disable iff (i_reset)
    !$past(i_reset) |-> o_target_mv == code_to_mv($past(ref_ff), $past(i_range_25mv)))
    else $error("millivolt target does not match step range");

endmodule

/* src/rail_volt_defs.svh */
`ifndef RAIL_VOLT_DEFS_SVH
`define RAIL_VOLT_DEFS_SVH

// Register offsets on the serial bus
`define OFS_RAIL4_SLEEP 8'h95
`define OFS_RAIL5_NORMAL 8'h96
`define OFS_RAIL5_SLEEP 8'h97
`define OFS_RAIL6_NORMAL 8'h98
`define REG_COUNT 4
`define IDX_RAIL4_SLEEP 2'h0
`define IDX_RAIL5_NORMAL 2'h1
`define IDX_RAIL5_SLEEP 2'h2
`define IDX_RAIL6_NORMAL 2'h3

// Field layout of every voltage register
`define CODE_MSB 7
`define CODE_LSB 1
`define RAMP_BIT 0

// Factory reset values, one per device variant
`define RST_R4S_V0 8'h28
`define RST_R4S_V1 8'h00
`define RST_R4S_V2 8'he8
`define RST_R4S_V3 8'ha8
`define RST_R5N_V0 8'h70
`define RST_R5N_V1 8'he8
`define RST_R5N_V2 8'h40
`define RST_R5N_V3 8'he8
`define RST_R5S_V0 8'h70
`define RST_R5S_V1 8'he8
`define RST_R5S_V2 8'h40
`define RST_R5S_V3 8'he8
`define RST_R6N_V0 8'hbe
`define RST_R6N_V1 8'hdc
`define RST_R6N_V2 8'h70
`define RST_R6N_V3 8'h58

// Serial bus: device address is arbitrary
`define I2C_DEV_ADDR 7'h5e
`define I2C_BYTE_BITS 4'h8
`define I2C_BIT_ZERO 4'h0

// Timing
`define MCLK_PERIOD_NS 40
`define SLEW_STEP_NS 1000
`define SLEW_STEP_CYC ((`SLEW_STEP_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

// Voltage step ranges
`define BASE_10MV_MV 12'h190
`define BASE_25MV_MV 12'h190
`define STEP_10MV_MV 12'h00a
`define STEP_25MV_MV 12'h019

`endif

/* src/rail_volt_pkg.sv */
package rail_volt_pkg;

  typedef struct packed {
    logic scl;
    logic sda;
    logic sleep_n;
    logic [2:0] range_25mv;
  } pin_t;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RDATA_ACK,
    ST_RD_LOAD
  } i2c_state_t;

endpackage
